/* File: sim/jlpr_link_param_regs_tb_top.sv */
`default_nettype none
module jlpr_link_param_regs_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cfg_wr = 1'b0;
   logic        cfg_rd = 1'b0;
   logic [11:0] cfg_addr = 12'h000;
   logic [7:0]  cfg_wdata = 8'h00;
   logic [7:0]  cfg_rdata;
   logic        cfg_hit;
   logic        descr_en;
   logic [4:0]  frm;
   logic [2:0]  tcv;
   int          err_count = 0;
   int          check_count = 0;
   always #12.5 clk = ~clk;
   jlpr_link_param_regs dut (.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit),
      .whitening_removal_enable(descr_en), .frames_per_mf_m1(frm), .timing_class_version(tcv));
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_wdata = d;
      @(negedge clk);
      cfg_wr = 1'b0;
   endtask : wr
   // read one register, compare hit flag and data
   task automatic rc(input logic [11:0] a, input logic [8:0] exp);
      @(negedge clk);
      cfg_rd = 1'b1;
      cfg_addr = a;
      @(negedge clk);
      cfg_rd = 1'b0;
      chk({cfg_hit, cfg_rdata}, exp);
   endtask : rc
   task automatic test_reset_values;
      rc(12'h453, 9'h187);
      rc(12'h454, 9'h100);
      rc(12'h455, 9'h11F);
      rc(12'h456, 9'h101);
      rc(12'h457, 9'h10F);
      rc(12'h458, 9'h10F);
      chk({descr_en, frm, tcv}, 9'h1F8);
   endtask : test_reset_values
   // write every offset, read back which fields took the data, then restore two fields
   task automatic test_writes;
      wr(12'h453, 8'h60);
      wr(12'h454, 8'hFF);
      wr(12'h455, 8'hEF);
      wr(12'h456, 8'hFF);
      wr(12'h457, 8'hFF);
      wr(12'h458, 8'h3F);
      rc(12'h453, 9'h107);
      rc(12'h454, 9'h100);
      rc(12'h455, 9'h10F);
      rc(12'h456, 9'h101);
      rc(12'h457, 9'h10F);
      rc(12'h458, 9'h12F);
      chk({descr_en, frm, tcv}, 9'h079);
      wr(12'h453, 8'h80);
      wr(12'h455, 8'h1F);
      rc(12'h453, 9'h187);
      rc(12'h455, 9'h11F);
   endtask : test_writes
   task automatic test_unmapped;
      wr(12'h459, 8'hFF);
      rc(12'h459, 9'h000);
      rc(12'h452, 9'h000);
   endtask : test_unmapped
   // write then read the same register on the very next edge
   task automatic test_back_to_back;
      @(negedge clk);
      cfg_wr = 1'b1;
      cfg_addr = 12'h458;
      cfg_wdata = 8'h00;
      @(negedge clk);
      cfg_wr = 1'b0;
      cfg_rd = 1'b1;
      @(negedge clk);
      cfg_rd = 1'b0;
      chk({cfg_hit, cfg_rdata}, 9'h10F);
   endtask : test_back_to_back
   // reset in mid-run returns every writable field to its reset value
   task automatic test_mid_reset;
      wr(12'h453, 8'h00);
      wr(12'h455, 8'h0F);
      wr(12'h458, 8'h20);
      @(negedge clk);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      chk({descr_en, frm, tcv}, 9'h1F8);
      rc(12'h453, 9'h187);
      rc(12'h458, 9'h10F);
   endtask : test_mid_reset
   task automatic complete_run;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   initial begin
      #20us;
      err_count++;
      complete_run();
   end
   initial begin
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      test_reset_values();
      test_writes();
      test_unmapped();
      test_back_to_back();
      test_mid_reset();
      complete_run();
   end
endmodule : jlpr_link_param_regs_tb_top
`default_nettype wire

/* File: verilog/jlpr_consts.svh */
`ifndef JLPR_CONSTS_SVH
`define JLPR_CONSTS_SVH
// register offsets on the configuration port
`define JLPR_ADDR_DESCR_LANE 12'h453
`define JLPR_ADDR_OCTETS     12'h454
`define JLPR_ADDR_FRAMES     12'h455
`define JLPR_ADDR_CONV       12'h456
`define JLPR_ADDR_CTRL_RES   12'h457
`define JLPR_ADDR_SUBCLASS   12'h458
// field positions
`define JLPR_DESCR_BIT       7
`define JLPR_SUBCLASS_LSB    5
// reset and fixed values
`define JLPR_RST_DESCR       1'h1
`define JLPR_RST_LANES       5'h07
`define JLPR_RST_OCTETS      8'h00
`define JLPR_RST_FRAMES      5'h1F
`define JLPR_RST_CONV        8'h01
`define JLPR_RST_CTRL_BITS   2'h0
`define JLPR_RST_RES         5'h0F
`define JLPR_RST_SUBCLASS    3'h0
`define JLPR_RST_SAMPLE_BITS 5'h0F
`endif

/* File: verilog/jlpr_link_param_regs.sv */
// Function
// - bit 7 enables descrambling, resets one
// - lane count minus one, read-only, 0x7
// - octets per frame read-only, not configuring
// - frames per multiframe writable, resets 0x1F
// - converters minus one read-only, 0x1
// - control bits per sample read zero
// - resolution minus one fixed 0x0F
// - subclass version writable bits 7:5, reset 0
`include "jlpr_consts.svh"
`default_nettype none
module jlpr_link_param_regs (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rst_n,
   // configuration port
   input  wire logic               cfg_wr,
   input  wire logic               cfg_rd,
   input  wire jlpr_pkg::jlpr_addr_t cfg_addr,
   input  wire jlpr_pkg::jlpr_byte_t cfg_wdata,
   output logic [7:0]              cfg_rdata,
   output logic                    cfg_hit,
   // link parameters to the receiver
   output logic                    whitening_removal_enable,
   output logic [4:0]              frames_per_mf_m1,
   output logic [2:0]              timing_class_version
);

   // one select per mapped offset
   logic       sel_lane;
   logic       sel_octets;
   logic       sel_frames;
   logic       sel_conv;
   logic       sel_ctrl_res;
   logic       sel_subcl;
   logic       sel_any;

   // descramble enable
   logic       descr_ff;
   logic       nxt_descr;

   // frames per multiframe minus one
   logic [4:0] frames_ff;
   logic [4:0] nxt_frames;

   // subclass version
   logic [2:0] subcl_ff;
   logic [2:0] nxt_subcl;

   // read return path and write enables
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic       hit_ff;
   logic       nxt_hit;
   logic [7:0] rd_val;
   logic       wr_lane;
   logic       wr_frames;
   logic       wr_subcl;

   function automatic logic is_mapped(input jlpr_pkg::jlpr_addr_t a);
      is_mapped = (a >= `JLPR_ADDR_DESCR_LANE) && (a <= `JLPR_ADDR_SUBCLASS);
   endfunction : is_mapped

   function automatic logic addr_is(input jlpr_pkg::jlpr_addr_t a, input jlpr_pkg::jlpr_addr_t b);
      addr_is = (a == b);
   endfunction : addr_is

   function automatic jlpr_pkg::jlpr_byte_t lane_byte(input logic d);
      lane_byte = {d, 2'h0, `JLPR_RST_LANES};
   endfunction : lane_byte

   function automatic jlpr_pkg::jlpr_byte_t frames_byte(input logic [4:0] v);
      frames_byte = {3'h0, v};
   endfunction : frames_byte

   function automatic jlpr_pkg::jlpr_byte_t ctrl_res_byte(input logic [4:0] res);
      ctrl_res_byte = {`JLPR_RST_CTRL_BITS, 1'h0, res};
   endfunction : ctrl_res_byte

   function automatic jlpr_pkg::jlpr_byte_t subcl_byte(input logic [2:0] v);
      subcl_byte = {v, `JLPR_RST_SAMPLE_BITS};
   endfunction : subcl_byte

   // address decode, shared by the read mux and the write enables
   always_comb begin
      sel_lane     = addr_is(cfg_addr, `JLPR_ADDR_DESCR_LANE);
      sel_octets   = addr_is(cfg_addr, `JLPR_ADDR_OCTETS);
      sel_frames   = addr_is(cfg_addr, `JLPR_ADDR_FRAMES);
      sel_conv     = addr_is(cfg_addr, `JLPR_ADDR_CONV);
      sel_ctrl_res = addr_is(cfg_addr, `JLPR_ADDR_CTRL_RES);
      sel_subcl    = addr_is(cfg_addr, `JLPR_ADDR_SUBCLASS);
      sel_any      = is_mapped(cfg_addr);
      wr_lane      = cfg_wr && sel_lane;
      wr_frames    = cfg_wr && sel_frames;
      wr_subcl     = cfg_wr && sel_subcl;
   end

   // read mux: fixed fields and reserved zeros
   always_comb begin
      rd_val = 8'h00;
      if (sel_lane) begin
         rd_val = lane_byte(descr_ff);
      end
      if (sel_octets) begin
         rd_val = `JLPR_RST_OCTETS;
      end
      if (sel_frames) begin
         rd_val = frames_byte(frames_ff);
      end
      if (sel_conv) begin
         rd_val = `JLPR_RST_CONV;
      end
      if (sel_ctrl_res) begin
         rd_val = ctrl_res_byte(`JLPR_RST_RES);
      end
      if (sel_subcl) begin
         rd_val = subcl_byte(subcl_ff);
      end
   end

   // descramble enable: only the top bit of the byte is stored
   always_comb begin
      nxt_descr = descr_ff;
      if (wr_lane) begin
         nxt_descr = cfg_wdata[`JLPR_DESCR_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         descr_ff <= `JLPR_RST_DESCR;
      end else begin
         descr_ff <= nxt_descr;
      end
   end

   always_comb begin
      nxt_frames = frames_ff;
      if (wr_frames) begin
         nxt_frames = cfg_wdata[4:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         frames_ff <= `JLPR_RST_FRAMES;
      end else begin
         frames_ff <= nxt_frames;
      end
   end

   always_comb begin
      nxt_subcl = subcl_ff;
      if (wr_subcl) begin
         nxt_subcl = cfg_wdata[7:`JLPR_SUBCLASS_LSB];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         subcl_ff <= `JLPR_RST_SUBCLASS;
      end else begin
         subcl_ff <= nxt_subcl;
      end
   end

   // read strobe captures the mux; writes to read-only or unmapped bytes fall away
   always_comb begin
      nxt_rdata = rdata_ff;
      nxt_hit   = 1'h0;
      if (cfg_rd) begin
         nxt_rdata = rd_val;
         nxt_hit   = sel_any;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
         hit_ff   <= 1'h0;
      end else begin
         rdata_ff <= nxt_rdata;
         hit_ff   <= nxt_hit;
      end
   end

   assign cfg_rdata                = rdata_ff;
   assign cfg_hit                  = hit_ff;
   assign whitening_removal_enable = descr_ff;
   assign frames_per_mf_m1         = frames_ff;
   assign timing_class_version     = subcl_ff;

   a_scr_write: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_wr && cfg_addr == `JLPR_ADDR_DESCR_LANE
      |=> descr_ff == $past(cfg_wdata[7]))
      else $error("descramble enable not written");

   a_descr_keep: assert property (@(posedge clk) disable iff (!rst_n)
      !(cfg_wr && cfg_addr == `JLPR_ADDR_DESCR_LANE)
      |=> $stable(descr_ff))
      else $error("descramble enable changed without write");

   a_descr_reset: assert property (@(posedge clk)
      $rose(rst_n)
      |-> descr_ff == 1'h1)
      else $error("descramble enable not one after reset");

   a_descr_read: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_rd && cfg_addr == `JLPR_ADDR_DESCR_LANE
      |=> cfg_rdata[7] == $past(descr_ff))
      else $error("descramble enable readback wrong");

   a_lane_read: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_rd && cfg_addr == `JLPR_ADDR_DESCR_LANE
      |=> cfg_rdata[6:0] == 7'h07)
      else $error("lane field wrong");

   a_octet_read: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_rd && cfg_addr == `JLPR_ADDR_OCTETS
      |=> cfg_rdata == 8'h00)
      else $error("octet field wrong");

   a_octet_no_config: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_wr && cfg_addr == `JLPR_ADDR_OCTETS
      |=> $stable(descr_ff) && $stable(frames_ff) && $stable(subcl_ff))
      else $error("octet write changed the setup");

   a_frames_write: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_wr && cfg_addr == `JLPR_ADDR_FRAMES
      |=> frames_ff == $past(cfg_wdata[4:0]))
      else $error("frames not written");

   a_frames_keep: assert property (@(posedge clk) disable iff (!rst_n)
      !(cfg_wr && cfg_addr == `JLPR_ADDR_FRAMES)
      |=> $stable(frames_ff))
      else $error("frames changed without write");

   a_frames_reset: assert property (@(posedge clk)
      $rose(rst_n)
      |-> frames_ff == 5'h1F)
      else $error("frames not 0x1F after reset");

   a_frames_read: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_rd && cfg_addr == `JLPR_ADDR_FRAMES
      |=> cfg_rdata[4:0] == $past(frames_ff))
      else $error("frames readback wrong");

   a_conv_read: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_rd && cfg_addr == `JLPR_ADDR_CONV
      |=> cfg_rdata == 8'h01)
      else $error("converter field wrong");

   a_csres_read: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_rd && cfg_addr == `JLPR_ADDR_CTRL_RES
      |=> cfg_rdata == 8'h0F)
      else $error("control and resolution wrong");

   a_ctrl_read: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_rd && cfg_addr == `JLPR_ADDR_CTRL_RES
      |=> cfg_rdata[7:6] == 2'h0)
      else $error("control bits not zero");

   a_res_read: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_rd && cfg_addr == `JLPR_ADDR_CTRL_RES
      |=> cfg_rdata[5:0] == 6'h0F)
      else $error("resolution field wrong");

   a_subcl_write: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_wr && cfg_addr == `JLPR_ADDR_SUBCLASS ##1 cfg_rd && cfg_addr == `JLPR_ADDR_SUBCLASS
      |=> cfg_rdata[7:5] == $past(cfg_wdata[7:5], 2))
      else $error("subclass readback wrong");

   a_subcl_keep: assert property (@(posedge clk) disable iff (!rst_n)
      !(cfg_wr && cfg_addr == `JLPR_ADDR_SUBCLASS)
      |=> $stable(subcl_ff))
      else $error("subclass changed without write");

   a_subcl_reset: assert property (@(posedge clk)
      $rose(rst_n)
      |-> subcl_ff == 3'h0)
      else $error("subclass not zero after reset");

   a_subcl_read: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_rd && cfg_addr == `JLPR_ADDR_SUBCLASS
      |=> cfg_rdata[7:5] == $past(subcl_ff) && cfg_rdata[4:0] == 5'h0F)
      else $error("subclass byte wrong");

   a_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_rd && cfg_addr == `JLPR_ADDR_FRAMES
      |=> cfg_rdata[7:5] == 3'h0 && cfg_hit)
      else $error("reserved bits not zero");

   a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_rd && (cfg_addr < `JLPR_ADDR_DESCR_LANE || cfg_addr > `JLPR_ADDR_SUBCLASS)
      |=> cfg_rdata == 8'h00 && !cfg_hit)
      else $error("unmapped read not zero");

   a_unmapped_write: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_wr && (cfg_addr < `JLPR_ADDR_DESCR_LANE || cfg_addr > `JLPR_ADDR_SUBCLASS)
      |=> $stable(descr_ff) && $stable(frames_ff) && $stable(subcl_ff))
      else $error("unmapped write changed a field");

endmodule : jlpr_link_param_regs
`default_nettype wire

/* File: verilog/jlpr_pkg.sv */
`default_nettype none
package jlpr_pkg;
   typedef logic [11:0] jlpr_addr_t;
   typedef logic [7:0]  jlpr_byte_t;
endpackage : jlpr_pkg
`default_nettype wire
